/* design/mms_pkg.sv */
/*
  Package of constants and types for the module management status and timing block.
  Assumes a 100 MHz system clock; ready and reset-pulse times are turned into cycle counts here.
*/
// How it works
// - Within 2000 ms, clear not-ready, assert interrupt
// - Interrupt on not-ready clear means fully functional
// - After reset release, functional within 2000 ms
// - Low-power select high: low power within 100 us
// - Interrupt low within 200 ms of condition
// - Flags clear on read; release within 500 us
// - Rx signal lost: flag and interrupt in 100 ms
// - Tx fault: flag and interrupt in 200 ms
// - Other flags: set and interrupt within 200 ms
// - Mask set stops interrupt within 100 ms
// - Mask clear resumes interrupt within 100 ms
// - Select asserted: answer bus within 100 us
// - Select released: stop answering within 100 us
// - Power-down bit set: low power within 100 ms
// - Power-down bit cleared: functional within 300 ms
// - Clear-on-read acts after read stop bit's falling edge
// - Mask/power writes act after write stop bit falling edge
package mms_pkg;
  localparam int unsigned CLK_MHZ       = 100;         // System clock rate
  localparam int unsigned INIT_MS       = 2000;        // Longest init time
  localparam int unsigned READY_MS      = 1000;        // Own init time used here
  localparam int unsigned LP_US         = 100;         // Low-power entry limit
  localparam int unsigned SEL_US        = 100;         // Select response limit
  localparam int unsigned RST_MIN_US    = 2;           // Least reset pulse
  localparam int unsigned READY_CYC     = READY_MS * 1000 * CLK_MHZ;   // Init count
  localparam int unsigned RST_MIN_CYC   = RST_MIN_US * CLK_MHZ;        // Reset filter count
  localparam int unsigned PWR_UP_CYC    = 16;          // Power-down exit settle
  localparam int          NFLAG         = 3;           // Rx lost, Tx fault, other
  localparam int          F_RXLOS       = 0;           // Flag index: rx signal lost
  localparam int          F_TXFLT       = 1;           // Flag index: tx fault
  localparam int          F_OTHER       = 2;           // Flag index: other
  localparam logic [NFLAG-1:0] FLAG_RST = 3'h0;        // Flags after reset
  localparam logic [NFLAG-1:0] MASK_RST = 3'h0;        // Masks after reset
  localparam logic [1:0]  SCL_FALL      = 2'h2;        // Previous 1, now 0

  typedef enum logic [1:0] {
    MMS_BOOT = 2'b00,  // Counting init time
    MMS_RUN  = 2'b01,  // Fully functional
    MMS_DOWN = 2'b10,  // Power-down forced
    MMS_WAKE = 2'b11   // Leaving power-down
  } mms_state_t;
endpackage : mms_pkg

/* design/mms_sync.sv */
/*
  Two-flop synchronisers for pins and serial clock fall detector.
  Assumes asynchronous pins; output on mclk.
*/
`timescale 1ns/10ps
module mms_sync
  import mms_pkg::*;
(
  input  wire logic  mclk,          // System clock
  input  wire logic  arst_n,        // Async reset
  input  wire logic  scl_pin,       // Serial clock pin
  input  wire logic  sel_n_pin,     // Select pin
  input  wire logic  lp_pin,        // Low-power pin
  input  wire logic  rst_n_pin,     // Module reset pin
  mms_sync_if.src    so             // Synchronised outputs
);
  logic [3:0] s1;                   // First stage
  logic [3:0] s2;                   // Second stage
  logic       scl_d;                // Delayed serial clock

  // Two-flop synchroniser for all four pins; reset to idle levels so no false event follows reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= 4'hB;                   // Reset high, low-power low, deselected, clock high
      s2 <= 4'hB;
    end else begin
      s1 <= {rst_n_pin, lp_pin, sel_n_pin, scl_pin};
      s2 <= s1;
    end
  end

  // Edge history of serial clock
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) scl_d <= 1'b1;     // Serial clock idles high
    else         scl_d <= s2[0];
  end

  assign so.scl_fall = ({scl_d, s2[0]} == SCL_FALL);
  assign so.sel_n    = s2[1];
  assign so.lp       = s2[2];
  assign so.rst_n    = s2[3];
endmodule : mms_sync

/* design/mms_sync_if.sv */
/*
  Interface carrying synchronised pin levels and serial clock fall events.
  Assumes producer and consumer share mclk.
*/
`timescale 1ns/10ps
interface mms_sync_if;
  logic scl_fall;     // One-cycle pulse on serial clock fall
  logic sel_n;        // Synchronised select
  logic lp;           // Synchronised low-power select
  logic rst_n;        // Synchronised module reset
  modport src (output scl_fall, sel_n, lp, rst_n);
  modport dst (input  scl_fall, sel_n, lp, rst_n);
endinterface : mms_sync_if

/* design/mms_top.sv */
/*
  Management control and status: readiness, flags, masks, interrupt, select, power.
  Assumes the serial bus engine reports reads, writes and stops on mclk.
*/
`timescale 1ns/10ps
module mms_top
  import mms_pkg::*;
#(
  parameter int unsigned READY_LIMIT = READY_CYC      // Init cycles; a bench may shorten it
)
(
  input  wire logic             mclk,                 // 100 MHz clock
  input  wire logic             arst_n,               // Async reset, low
  input  wire logic             scl,                  // Serial clock pin
  input  wire logic             module_select_n,      // Select pin, low
  input  wire logic             low_power_select,     // Low-power pin
  input  wire logic             module_reset_n,       // Module reset pin, low
  input  wire logic [NFLAG-1:0] cond,                 // Raw flag conditions
  input  wire logic             rd_flags,             // Bus read of flags done
  input  wire logic             wr_ctrl,              // Bus write of controls done
  input  wire logic [NFLAG-1:0] wr_mask,              // Written mask value
  input  wire logic             wr_pdown,             // Written power-down bit
  input  wire logic             stop_seen,            // Stop bit seen on bus
  output logic                  interrupt_request_n,  // Interrupt, low
  output logic                  data_not_ready,       // Not-ready status bit
  output logic [NFLAG-1:0]      flags,                // Latched flags
  output logic [NFLAG-1:0]      mask,                 // Active masks
  output logic                  pdown,                // Active power-down bit
  output logic                  bus_enable,           // Answer serial bus
  output logic                  low_power             // Low power level
);
  mms_sync_if sy ();                                  // Synchronised pins

  mms_sync u_sync (
    .mclk      (mclk),
    .arst_n    (arst_n),
    .scl_pin   (scl),
    .sel_n_pin (module_select_n),
    .lp_pin    (low_power_select),
    .rst_n_pin (module_reset_n),
    .so        (sy)
  );

  mms_state_t       state;          // Readiness state
  logic [31:0]      cnt;            // Timer
  logic [7:0]       rst_cnt;        // Reset low duration
  logic             mrst;           // Module reset in effect
  logic             rd_pend;        // Clear-on-read waiting for fall
  logic             wr_pend;        // Write waiting for fall
  logic [NFLAG-1:0] hold_mask;      // Pending mask value
  logic             hold_pd;        // Pending power-down value
  logic [NFLAG-1:0] next_flags;     // Flag update
  logic             ready_ev;       // Init count done; not-ready clears at next edge
  logic             ready_irq;      // Sticky readiness interrupt

  // Module reset only after low longer than minimum pulse
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_cnt <= 8'h00;
      mrst    <= 1'b1;
    end else if (sy.rst_n) begin
      rst_cnt <= 8'h00;
      mrst    <= 1'b0;
    end else if (rst_cnt >= RST_MIN_CYC[7:0]) begin
      mrst    <= 1'b1;
    end else begin
      rst_cnt <= rst_cnt + 8'h01;
    end
  end

  // Capture bus events; apply them at next serial clock fall after stop
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_pend   <= 1'b0;
      wr_pend   <= 1'b0;
      hold_mask <= MASK_RST;
      hold_pd   <= 1'b0;
    end else if (mrst) begin
      rd_pend   <= 1'b0;
      wr_pend   <= 1'b0;
    end else begin
      if (stop_seen && rd_flags) rd_pend <= 1'b1;
      else if (sy.scl_fall)      rd_pend <= 1'b0;
      if (stop_seen && wr_ctrl) begin
        wr_pend   <= 1'b1;
        hold_mask <= wr_mask;
        hold_pd   <= wr_pdown;
      end else if (sy.scl_fall) begin
        wr_pend   <= 1'b0;
      end
    end
  end

  // Mask and power-down take effect at the fall
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mask  <= MASK_RST;
      pdown <= 1'b0;
    end else if (mrst) begin
      mask  <= MASK_RST;
      pdown <= 1'b0;
    end else if (wr_pend && sy.scl_fall) begin
      mask  <= hold_mask;
      pdown <= hold_pd;
    end
  end

  // Flag latch: set wins over clear-on-read
  always_comb begin
    next_flags = flags;
    if (rd_pend && sy.scl_fall) next_flags = FLAG_RST;
    next_flags = next_flags | cond;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n)   flags <= FLAG_RST;
    else if (mrst) flags <= FLAG_RST;
    else           flags <= next_flags;
  end

  // Readiness state machine
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state <= MMS_BOOT;
      cnt   <= 32'h0;
    end else if (mrst) begin
      state <= MMS_BOOT;
      cnt   <= 32'h0;
    end else begin
      case (state)
        MMS_BOOT: begin
          if (cnt >= READY_LIMIT) begin
            state <= MMS_RUN;
            cnt   <= 32'h0;
          end else begin
            cnt <= cnt + 32'h1;
          end
        end
        MMS_RUN: begin
          if (pdown) state <= MMS_DOWN;
        end
        MMS_DOWN: begin
          if (!pdown) begin
            state <= MMS_WAKE;
            cnt   <= 32'h0;
          end
        end
        MMS_WAKE: begin
          if (pdown) state <= MMS_DOWN;
          else if (cnt >= PWR_UP_CYC) state <= MMS_RUN;
          else cnt <= cnt + 32'h1;
        end
        default: state <= MMS_BOOT;
      endcase
    end
  end

  assign ready_ev = (state == MMS_BOOT) && (cnt >= READY_LIMIT) && !mrst;

  // Not-ready bit and readiness interrupt; read clears the latter
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      data_not_ready <= 1'b1;
      ready_irq      <= 1'b0;
    end else if (mrst) begin
      data_not_ready <= 1'b1;
      ready_irq      <= 1'b0;
    end else if (ready_ev) begin
      data_not_ready <= 1'b0;
      ready_irq      <= 1'b1;
    end else if (rd_pend && sy.scl_fall) begin
      ready_irq      <= 1'b0;
    end
  end

  // Interrupt while any unmasked source is set
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n)   interrupt_request_n <= 1'b1;
    else if (mrst) interrupt_request_n <= 1'b1;
    else interrupt_request_n <= ~(ready_irq | (|(flags & ~mask)));
  end

  // Bus response follows select; low power follows pin or bit
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bus_enable <= 1'b0;
      low_power  <= 1'b0;
    end else begin
      bus_enable <= ~sy.sel_n & ~mrst;
      // Power-down bit acts in every state, boot included
      low_power  <= sy.lp | pdown | (state == MMS_DOWN);
    end
  end
endmodule : mms_top

/* test/mms_host.sv */
/* Host model: ends each transfer with a stop, then one serial clock fall.
   Assumes mclk from the bench; scl idles high, driven by this model. */
`timescale 1ns/10ps
module mms_host
  import mms_pkg::*;
(
  input  wire logic        mclk,      // System clock
  output logic             scl,       // Serial clock, idles high
  output logic             stop_seen, // Stop pulse
  output logic             rd_flags,  // Flags byte read
  output logic             wr_ctrl,   // Controls written
  output logic [NFLAG-1:0] wr_mask,   // Mask data
  output logic             wr_pdown   // Power-down data
);
  // Idle bus at time zero
  initial begin
    scl = 1'b1;
    stop_seen = 1'b0;
    rd_flags = 1'b0;
    wr_ctrl = 1'b0;
    wr_mask = 3'h0;
    wr_pdown = 1'b0;
  end
  // One read or write; gap sets a prompt or slow clock fall
  task automatic xfer(input logic rd, input logic [2:0] m, input logic p, input int gap);
    @(negedge mclk);
    stop_seen = 1'b1;
    rd_flags = rd;
    wr_ctrl = !rd;
    wr_mask = m;
    wr_pdown = p;
    @(negedge mclk);
    stop_seen = 1'b0;
    rd_flags = 1'b0;
    wr_ctrl = 1'b0;
    wr_mask = ~m;
    wr_pdown = ~p;
    repeat (gap) @(negedge mclk);
    scl = 1'b0;
    repeat (4) @(negedge mclk);
    scl = 1'b1;
    repeat (8) @(negedge mclk);
  endtask : xfer
endmodule : mms_host

/* test/mms_top_asserts.sv */
/* Port checker for mms_top: flag, interrupt, select and power timing.
   Assumes the bench drives pins off the falling clock edge; bound below. */
`timescale 1ns/10ps
module mms_top_asserts
  import mms_pkg::*;
(
  input wire logic             mclk,                // Clock
  input wire logic             arst_n,              // Async reset
  input wire logic             scl,                 // Serial clock pin
  input wire logic             module_select_n,     // Select pin
  input wire logic             low_power_select,    // Low-power pin
  input wire logic             module_reset_n,      // Module reset pin
  input wire logic [NFLAG-1:0] cond,                // Raw conditions
  input wire logic             rd_flags,            // Flags read
  input wire logic             stop_seen,           // Stop pulse
  input wire logic             interrupt_request_n, // Interrupt
  input wire logic             data_not_ready,      // Not-ready bit
  input wire logic [NFLAG-1:0] flags,               // Flags
  input wire logic [NFLAG-1:0] mask,                // Masks
  input wire logic             pdown,               // Power-down bit
  input wire logic             bus_enable,          // Bus answer
  input wire logic             low_power            // Low power
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  logic [NFLAG-1:0] unmasked;  // Flags able to interrupt
  logic [8:0]       rst_low;   // Cycles module reset held low
  assign unmasked = flags & ~mask;
  // Count module reset low time, saturating
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) rst_low <= 9'h000;
    else if (module_reset_n) rst_low <= 9'h000;
    else if (rst_low != 9'h1FF) rst_low <= rst_low + 9'h001;
  end
  sequence s_read; stop_seen && rd_flags; endsequence
  sequence s_unm2; (|unmasked)[*2]; endsequence
  property p_rxlos; cond[F_RXLOS] && module_reset_n |-> ##[1:3] flags[F_RXLOS]; endproperty
  property p_txflt; cond[F_TXFLT] && module_reset_n |-> ##[1:3] flags[F_TXFLT]; endproperty
  property p_other; cond[F_OTHER] && module_reset_n |-> ##[1:3] flags[F_OTHER]; endproperty
  property p_irq_on; s_unm2 |-> !interrupt_request_n; endproperty
  property p_irq_off; (unmasked == 3'h0)[*3] ##0 data_not_ready |-> interrupt_request_n; endproperty
  property p_rel; $rose(interrupt_request_n) && module_reset_n |-> $past(unmasked) == 3'h0; endproperty
  property p_cor; $fell(|flags) && module_reset_n |-> !$past(scl, 2) ##[0:2] interrupt_request_n; endproperty
  property p_wr; !$stable(mask) && module_reset_n |-> !$past(scl, 2); endproperty
  property p_sel_on; $fell(module_select_n) |-> ##[1:5] bus_enable; endproperty
  property p_sel_off; $rose(module_select_n) |-> ##[1:5] !bus_enable; endproperty
  property p_lp; $rose(low_power_select) |-> ##[1:5] low_power; endproperty
  property p_pd; $rose(pdown) |-> ##[0:3] low_power; endproperty
  property p_wake; $fell(pdown) && !low_power_select |-> ##[1:24] !low_power; endproperty
  property p_rst; rst_low > 9'h0E0 |-> flags == 3'h0 && data_not_ready && interrupt_request_n; endproperty
  a_rxlos: assert property (p_rxlos) else $error("rx lost flag late");
  a_txflt: assert property (p_txflt) else $error("tx fault flag late");
  a_other: assert property (p_other) else $error("other flag late");
  a_irq_on: assert property (p_irq_on) else $error("interrupt not held");
  a_irq_off: assert property (p_irq_off) else $error("interrupt not released");
  a_rel: assert property (p_rel) else $error("interrupt released early");
  a_cor: assert property (p_cor) else $error("clear on read timing");
  a_wr: assert property (p_wr) else $error("mask write timing");
  a_sel_on: assert property (p_sel_on) else $error("bus not answered");
  a_sel_off: assert property (p_sel_off) else $error("bus still answered");
  a_lp: assert property (p_lp) else $error("low power late");
  a_pd: assert property (p_pd) else $error("power-down late");
  a_wake: assert property (p_wake) else $error("wake late");
  a_rst: assert property (p_rst) else $error("reset state wrong");
  c_read: cover property (s_read);
endmodule : mms_top_asserts

bind mms_top mms_top_asserts u_chk (.*);

/* test/mms_top_bench.sv */
/* Bench for mms_top: pins and conditions here, bus events from mms_host.
   Assumes the host model and bound checker are compiled first. */
`timescale 1ns/10ps
module mms_top_bench
  import mms_pkg::*;
;
  localparam int unsigned READY_LIM = 100;  // Shortened init count so readiness is seen in the run
  logic       mclk, arst_n, scl, module_select_n, low_power_select, module_reset_n;
  logic [2:0] cond, wr_mask, flags, mask, ef, em;
  logic       rd_flags, wr_ctrl, wr_pdown, stop_seen, interrupt_request_n;
  logic       data_not_ready, pdown, bus_enable, low_power, epd, edr, eri;
  int         err_total, total_checks;
  mms_top #(.READY_LIMIT(READY_LIM)) dut (.*);
  mms_host host (.*);
  always #5 mclk = ~mclk;
  // Report counts, give the verdict and stop
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  // Settle, then compare all outputs with the expected state
  task automatic check;
    logic [10:0] got;
    logic [10:0] exp;
    repeat (30) @(negedge mclk);
    got = {data_not_ready, interrupt_request_n, flags, mask, pdown, bus_enable, low_power};
    exp = {edr, ~(eri | (|(ef & ~em))), ef, em, epd, ~module_select_n, low_power_select | epd};
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // Bounded wait for the not-ready bit to clear; running out ends the run
  task automatic wait_ready;
    int n;
    n = 0;
    while (data_not_ready !== 1'b0 && n < READY_LIM) begin
      @(negedge mclk);
      n++;
    end
    total_checks++;
    if (data_not_ready !== 1'b0) begin
      err_total++;
      $display("ERROR t=%0t got %h exp %h", $time, data_not_ready, 1'b0);
      end_sim;
    end
  endtask : wait_ready
  // Pulse one condition for a cycle
  task automatic pulse(input int i);
    cond[i] = 1'b1;
    @(negedge mclk);
    cond = 3'h0;
  endtask : pulse
  initial begin
    mclk = 1'b0;
    arst_n = 1'b0;
    module_select_n = 1'b1;
    low_power_select = 1'b0;
    module_reset_n = 1'b1;
    cond = 3'h0;
    ef = 3'h0;
    em = 3'h0;
    epd = 1'b0;
    edr = 1'b1;
    eri = 1'b0;
    err_total = 0;
    total_checks = 0;
    repeat (6) @(negedge mclk);
    arst_n = 1'b1;
    check;
    wait_ready;
    edr = 1'b0;
    eri = 1'b1;
    check;
    host.xfer(1'b1, 3'h0, 1'b0, 2);
    eri = 1'b0;
    check;
    for (int i = 0; i < NFLAG; i++) begin
      pulse(i);
      ef[i] = 1'b1;
      check;
    end
    host.xfer(1'b1, 3'h0, 1'b0, 20);
    ef = 3'h0;
    check;
    pulse(F_TXFLT);
    ef = 3'h2;
    check;
    host.xfer(1'b0, 3'h7, 1'b0, 2);
    em = 3'h7;
    check;
    host.xfer(1'b0, 3'h5, 1'b0, 2);
    em = 3'h5;
    check;
    host.xfer(1'b1, 3'h0, 1'b0, 2);
    ef = 3'h0;
    check;
    host.xfer(1'b0, 3'h0, 1'b1, 2);
    em = 3'h0;
    epd = 1'b1;
    check;
    host.xfer(1'b0, 3'h0, 1'b0, 2);
    epd = 1'b0;
    check;
    low_power_select = 1'b1;
    check;
    low_power_select = 1'b0;
    module_select_n = 1'b0;
    check;
    module_select_n = 1'b1;
    check;
    pulse(F_OTHER);
    module_reset_n = 1'b0;
    ef = 3'h0;
    edr = 1'b1;
    repeat (250) @(negedge mclk);
    check;
    module_reset_n = 1'b1;
    check;
    wait_ready;
    edr = 1'b0;
    eri = 1'b1;
    check;
    end_sim;
  end
endmodule : mms_top_bench
